// file: rtl/epm_top.v
// engine protection monitor with ahb-lite register slave
// Operation
// - overspeed above threshold shuts the engine down
// - overspeed shutdown raised at once, also when threshold is lowered
// - oil and coolant raise a warning when warning threshold reached
// - oil and coolant raise a separate shutdown at shutdown threshold
// - oil shutdown only after pressure low for programmed delay
// - coolant shutdown only after temperature high for programmed delay
// - oil shutdown masked while stopped and until mask timer expires
// - coolant shutdown masked while stopped and until mask timer expires
// - mask timer starts when speed reaches crank terminate speed
// - mask timer runs programmed delay, then enables masked shutdowns
// - coolant shutdown threshold below 49 C is rejected
// - hours accumulate while speed is above crank terminate speed
// - hours write accepted only if not lower than present count
// - hours write only from local display with level 3 active
// - overspeed threshold from display needs level 3, tool needs none
// - emergency stop input polarity selectable high or low
// - overspeed, oil and coolant shutdowns latch active after clearing and block restart until cleared at the event clear register
// - warnings clear themselves when the condition goes away
`timescale 1ns/1ns
`include "epm_regs.vh"
module epm_top #(
  parameter DW         = 16,
  parameter TICK_CYC   = `EPM_TICK_CYC,
  parameter TICKS_HOUR = `EPM_TICKS_HOUR
) (
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          hsel,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  input  wire [DW-1:0] eng_speed,
  input  wire [DW-1:0] oil_press,
  input  wire [DW-1:0] cool_temp,
  input  wire          estop_pin,
  output reg           shutdown,
  output reg           oil_warn,
  output reg           cool_warn,
  output reg           restart_inhibit
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam [1:0] ST_OFF  = 2'd0;
  localparam [1:0] ST_TIME = 2'd1;
  localparam [1:0] ST_DONE = 2'd2;

  reg  [DW-1:0] spd_m_q, spd_s_q;
  reg  [DW-1:0] oil_m_q, oil_s_q;
  reg  [DW-1:0] cool_m_q, cool_s_q;
  reg           estop_m_q, estop_s_q;

  reg  [`EPM_CTRL_W-1:0] ctrl_q;
  reg  [DW-1:0] ovs_thr_q;
  reg  [DW-1:0] oil_warn_thr_q;
  reg  [DW-1:0] oil_sd_thr_q;
  reg  [DW-1:0] oil_dly_q;
  reg  [DW-1:0] cool_warn_thr_q;
  reg  [DW-1:0] cool_sd_thr_q;
  reg  [DW-1:0] cool_dly_q;
  reg  [DW-1:0] mask_dly_q;
  reg  [DW-1:0] crank_spd_q;
  reg  [31:0]   hours_q;
  reg           reject_q;

  reg           wr_q;
  reg  [7:0]    waddr_q;
  reg  [31:0]   rd_d;

  reg  [31:0]   tick_cnt_q;
  reg           tick_q;
  reg  [31:0]   run_ticks_q;

  reg  [1:0]    mask_st_q;
  reg  [DW-1:0] mask_cnt_q;

  reg           ovs_pres_q;
  reg           estop_q;
  reg  [2:0]    lat_q;

  wire          addr_ph;
  wire          wr_ok;
  wire          running;
  wire          stopped;
  wire          mask_done;
  wire          oil_low;
  wire          cool_high;
  wire          oil_sd_q;
  wire          cool_sd_q;
  wire [2:0]    pres;
  wire          level3_disp;
  wire          tool_path;

  // ----------------------------------------------------------------
  // helper: has a value reached its threshold, high or low side
  // ----------------------------------------------------------------
  function reached;
    input [DW-1:0] val;
    input [DW-1:0] thr;
    input          high_side;
    begin
      if (high_side) begin
        reached = (val >= thr);
      end else begin
        reached = (val <= thr);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers, two flops before any logic
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spd_m_q   <= {DW{1'b0}};
      spd_s_q   <= {DW{1'b0}};
      oil_m_q   <= {DW{1'b0}};
      oil_s_q   <= {DW{1'b0}};
      cool_m_q  <= {DW{1'b0}};
      cool_s_q  <= {DW{1'b0}};
      estop_m_q <= 1'b0;
      estop_s_q <= 1'b0;
    end else begin
      spd_m_q   <= eng_speed;
      spd_s_q   <= spd_m_q;
      oil_m_q   <= oil_press;
      oil_s_q   <= oil_m_q;
      cool_m_q  <= cool_temp;
      cool_s_q  <= cool_m_q;
      estop_m_q <= estop_pin;
      estop_s_q <= estop_m_q;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite address phase and write qualifiers
  // ----------------------------------------------------------------
  assign addr_ph     = hsel && htrans[1] && hready;
  assign wr_ok       = wr_q;
  assign level3_disp = ctrl_q[`EPM_CTRL_DISPLAY] && ctrl_q[`EPM_CTRL_LEVEL3];
  assign tool_path   = !ctrl_q[`EPM_CTRL_DISPLAY];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      waddr_q   <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;                  // zero wait states
      hresp     <= 1'b0;                  // always okay
      wr_q      <= addr_ph && hwrite;
      if (addr_ph) begin
        waddr_q <= haddr[7:0];
      end
      if (addr_ph && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux, unmapped offsets read as zero
  // ----------------------------------------------------------------
  always @* begin
    rd_d   = 32'h0000_0000;
    case (haddr[7:0])
      `EPM_OFF_CTRL:      rd_d[`EPM_CTRL_W-1:0] = ctrl_q;
      `EPM_OFF_OVS_THR:   rd_d[DW-1:0] = ovs_thr_q;
      `EPM_OFF_OIL_WARN:  rd_d[DW-1:0] = oil_warn_thr_q;
      `EPM_OFF_OIL_SD:    rd_d[DW-1:0] = oil_sd_thr_q;
      `EPM_OFF_OIL_DLY:   rd_d[DW-1:0] = oil_dly_q;
      `EPM_OFF_COOL_WARN: rd_d[DW-1:0] = cool_warn_thr_q;
      `EPM_OFF_COOL_SD:   rd_d[DW-1:0] = cool_sd_thr_q;
      `EPM_OFF_COOL_DLY:  rd_d[DW-1:0] = cool_dly_q;
      `EPM_OFF_MASK_DLY:  rd_d[DW-1:0] = mask_dly_q;
      `EPM_OFF_CRANK_SPD: rd_d[DW-1:0] = crank_spd_q;
      `EPM_OFF_HOURS:     rd_d = hours_q;
      `EPM_OFF_STATUS: begin
        rd_d[`EPM_ST_OIL_WARN]  = oil_warn;
        rd_d[`EPM_ST_COOL_WARN] = cool_warn;
        rd_d[`EPM_ST_PRES_LSB+2:`EPM_ST_PRES_LSB] = pres;
        rd_d[`EPM_ST_LAT_LSB+2:`EPM_ST_LAT_LSB]   = lat_q;
        rd_d[`EPM_ST_MASK_DONE] = mask_done;
        rd_d[`EPM_ST_RUNNING]   = running;
        rd_d[`EPM_ST_ESTOP]     = estop_q;
        rd_d[`EPM_ST_INHIBIT]   = restart_inhibit;
        rd_d[`EPM_ST_REJECT]    = reject_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // configuration registers, written in the data phase
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q          <= `EPM_RST_CTRL;
      ovs_thr_q       <= `EPM_RST_OVS_THR;
      oil_warn_thr_q  <= `EPM_RST_OIL_WARN;
      oil_sd_thr_q    <= `EPM_RST_OIL_SD;
      oil_dly_q       <= `EPM_RST_OIL_DLY;
      cool_warn_thr_q <= `EPM_RST_COOL_WARN;
      cool_sd_thr_q   <= `EPM_RST_COOL_SD;
      cool_dly_q      <= `EPM_RST_COOL_DLY;
      mask_dly_q      <= `EPM_RST_MASK_DLY;
      crank_spd_q     <= `EPM_RST_CRANK_SPD;
      reject_q        <= 1'b0;
    end else if (wr_ok) begin
      case (waddr_q)
        `EPM_OFF_CTRL:      ctrl_q <= hwdata[`EPM_CTRL_W-1:0];
        `EPM_OFF_OVS_THR: begin
          if (tool_path || level3_disp) begin
            ovs_thr_q <= hwdata[DW-1:0];
            reject_q  <= 1'b0;
          end else begin
            reject_q  <= 1'b1;
          end
        end
        `EPM_OFF_OIL_WARN:  oil_warn_thr_q  <= hwdata[DW-1:0];
        `EPM_OFF_OIL_SD:    oil_sd_thr_q    <= hwdata[DW-1:0];
        `EPM_OFF_OIL_DLY:   oil_dly_q       <= hwdata[DW-1:0];
        `EPM_OFF_COOL_WARN: cool_warn_thr_q <= hwdata[DW-1:0];
        `EPM_OFF_COOL_SD: begin
          if (hwdata[DW-1:0] >= `EPM_COOL_SD_MIN) begin
            cool_sd_thr_q <= hwdata[DW-1:0];
            reject_q      <= 1'b0;
          end else begin
            reject_q      <= 1'b1;
          end
        end
        `EPM_OFF_COOL_DLY:  cool_dly_q  <= hwdata[DW-1:0];
        `EPM_OFF_MASK_DLY:  mask_dly_q  <= hwdata[DW-1:0];
        `EPM_OFF_CRANK_SPD: crank_spd_q <= hwdata[DW-1:0];
        `EPM_OFF_HOURS: begin
          reject_q <= !(level3_disp && (hwdata >= hours_q));
        end
        default: reject_q <= reject_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // delay tick prescaler
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= TICK_CYC - 1) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // engine state from speed
  // ----------------------------------------------------------------
  assign running = spd_s_q > crank_spd_q;
  assign stopped = spd_s_q == {DW{1'b0}};

  // ----------------------------------------------------------------
  // operating hours, counted and software-raised
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ticks_q <= 32'h0000_0000;
      hours_q     <= 32'h0000_0000;
    end else begin
      if (wr_ok && (waddr_q == `EPM_OFF_HOURS) && level3_disp
          && (hwdata >= hours_q)) begin
        hours_q <= hwdata;
      end else if (tick_q && running) begin
        if (run_ticks_q >= TICKS_HOUR - 1) begin
          run_ticks_q <= 32'h0000_0000;
          hours_q     <= hours_q + 32'h0000_0001;
        end else begin
          run_ticks_q <= run_ticks_q + 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // start protection mask timer
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_st_q  <= ST_OFF;
      mask_cnt_q <= {DW{1'b0}};
    end else begin
      case (mask_st_q)
        ST_OFF: begin
          mask_cnt_q <= {DW{1'b0}};
          if (spd_s_q >= crank_spd_q && !stopped) begin
            mask_st_q <= ST_TIME;
          end
        end
        ST_TIME: begin
          if (stopped) begin
            mask_st_q <= ST_OFF;
          end else if (mask_cnt_q >= mask_dly_q) begin
            mask_st_q <= ST_DONE;
          end else if (tick_q) begin
            mask_cnt_q <= mask_cnt_q + 1'b1;
          end
        end
        ST_DONE: begin
          if (stopped) begin
            mask_st_q <= ST_OFF;
          end
        end
        default: mask_st_q <= ST_OFF;
      endcase
    end
  end

  assign mask_done = mask_st_q == ST_DONE;

  // ----------------------------------------------------------------
  // shutdown delay qualifiers
  // ----------------------------------------------------------------
  assign oil_low   = reached(oil_s_q, oil_sd_thr_q, 1'b0) && mask_done;
  assign cool_high = reached(cool_s_q, cool_sd_thr_q, 1'b1) && mask_done;

  epm_qual #(.DW(DW)) u_oil_qual (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_q),
    .cond    (oil_low),
    .dly     (oil_dly_q),
    .qual_q  (oil_sd_q)
  );

  epm_qual #(.DW(DW)) u_cool_qual (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_q),
    .cond    (cool_high),
    .dly     (cool_dly_q),
    .qual_q  (cool_sd_q)
  );

  // ----------------------------------------------------------------
  // present and latched shutdown events, set wins over clear
  // ----------------------------------------------------------------
  assign pres = {cool_sd_q, oil_sd_q, ovs_pres_q};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovs_pres_q <= 1'b0;
      estop_q    <= 1'b0;
      lat_q      <= 3'h0;
    end else begin
      ovs_pres_q <= spd_s_q > ovs_thr_q;
      estop_q    <= (estop_s_q == ctrl_q[`EPM_CTRL_ESTOP_HI]);
      if (wr_ok && (waddr_q == `EPM_OFF_EVT_CLR)) begin
        lat_q <= pres | (lat_q &
                 ~hwdata[`EPM_ST_LAT_LSB+2:`EPM_ST_LAT_LSB]);
      end else begin
        lat_q <= pres | lat_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // protection outputs
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shutdown        <= 1'b0;
      restart_inhibit <= 1'b0;
      oil_warn        <= 1'b0;
      cool_warn       <= 1'b0;
    end else begin
      shutdown        <= (|pres) || (|lat_q) || estop_q;
      restart_inhibit <= (|pres) || (|lat_q);
      oil_warn  <= reached(oil_s_q, oil_warn_thr_q, 1'b0);
      cool_warn <= reached(cool_s_q, cool_warn_thr_q, 1'b1);
    end
  end

endmodule // epm_top

// file: pkg/epm_regs.vh
// register offsets, field positions, reset values and timing for epm
`ifndef EPM_REGS_VH
`define EPM_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EPM_OFF_CTRL      8'h00
`define EPM_OFF_OVS_THR   8'h04
`define EPM_OFF_OIL_WARN  8'h08
`define EPM_OFF_OIL_SD    8'h0c
`define EPM_OFF_OIL_DLY   8'h10
`define EPM_OFF_COOL_WARN 8'h14
`define EPM_OFF_COOL_SD   8'h18
`define EPM_OFF_COOL_DLY  8'h1c
`define EPM_OFF_MASK_DLY  8'h20
`define EPM_OFF_CRANK_SPD 8'h24
`define EPM_OFF_HOURS     8'h28
`define EPM_OFF_STATUS    8'h2c
`define EPM_OFF_EVT_CLR   8'h30

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define EPM_CTRL_ESTOP_HI 0
`define EPM_CTRL_DISPLAY  1
`define EPM_CTRL_LEVEL3   2
`define EPM_CTRL_W        3

// ----------------------------------------------------------------
// status fields (latched bits also used by the event clear)
// ----------------------------------------------------------------
`define EPM_ST_OIL_WARN   0
`define EPM_ST_COOL_WARN  1
`define EPM_ST_PRES_LSB   2
`define EPM_ST_LAT_LSB    5
`define EPM_ST_MASK_DONE  8
`define EPM_ST_RUNNING    9
`define EPM_ST_ESTOP      10
`define EPM_ST_INHIBIT    11
`define EPM_ST_REJECT     12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EPM_RST_CTRL      3'h0
`define EPM_RST_OVS_THR   16'h0834
`define EPM_RST_OIL_WARN  16'h00cd
`define EPM_RST_OIL_SD    16'h00a5
`define EPM_RST_OIL_DLY   16'h03e8
`define EPM_RST_COOL_WARN 16'h0064
`define EPM_RST_COOL_SD   16'h006e
`define EPM_RST_COOL_DLY  16'h03e8
`define EPM_RST_MASK_DLY  16'h2710
`define EPM_RST_CRANK_SPD 16'h0190
`define EPM_COOL_SD_MIN   16'h0031

// ----------------------------------------------------------------
// timing: hclk period and delay tick in ns, hours in ticks
// ----------------------------------------------------------------
`define EPM_CLK_NS        10
`define EPM_TICK_NS       1000000
`define EPM_TICK_CYC      (`EPM_TICK_NS / `EPM_CLK_NS)
`define EPM_TICKS_HOUR    3600000

`endif

// file: rtl/epm_qual.v
// delay qualifier: condition must hold for a programmed number of ticks
`timescale 1ns/1ns
module epm_qual #(
  parameter DW = 16
) (
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          tick,
  input  wire          cond,
  input  wire [DW-1:0] dly,
  output reg           qual_q
);

  reg [DW-1:0] cnt_q;

  // ----------------------------------------------------------------
  // tick counter, restarts when the value returns to the safe side
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= {DW{1'b0}};
      qual_q <= 1'b0;
    end else begin
      if (!cond) begin
        cnt_q <= {DW{1'b0}};
      end else if (tick && (cnt_q < dly)) begin
        cnt_q <= cnt_q + 1'b1;
      end
      qual_q <= cond && (cnt_q >= dly);
    end
  end

endmodule // epm_qual

// file: verif/epm_properties.sv
// concurrent checks on the ports of the engine protection monitor
`timescale 1ns/1ns
`include "epm_regs.vh"
module epm_checker #(
  parameter DW = 16
) (
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [31:0]   hwdata,
  input wire logic          hready,
  input wire logic [31:0]   hrdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic [DW-1:0] eng_speed,
  input wire logic          estop_pin,
  input wire logic          shutdown,
  input wire logic          restart_inhibit
);
  logic          wr_q;
  logic [7:0]    adr_q;
  logic [2:0]    ctrl_q;
  logic [DW-1:0] ovs_q;
  logic [7:0]    clr_age_q;
  logic          rd_req;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // read request taken at this edge
  assign rd_req = hsel & htrans[1] & hready & ~hwrite;

  // shadow of control and overspeed limit, age of the last latch clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      adr_q     <= 8'h00;
      ctrl_q    <= 3'h0;
      ovs_q     <= `EPM_RST_OVS_THR;
      clr_age_q <= 8'hff;
    end else begin
      wr_q  <= hsel & htrans[1] & hready & hwrite;
      adr_q <= haddr[7:0];
      if (wr_q && adr_q == `EPM_OFF_CTRL) ctrl_q <= hwdata[2:0];
      if (wr_q && adr_q == `EPM_OFF_OVS_THR &&
          (!ctrl_q[`EPM_CTRL_DISPLAY] || ctrl_q[`EPM_CTRL_LEVEL3]))
        ovs_q <= hwdata[DW-1:0];
      if (wr_q && adr_q == `EPM_OFF_EVT_CLR) clr_age_q <= 8'h00;
      else if (clr_age_q != 8'hff) clr_age_q <= clr_age_q + 8'h01;
    end
  end

  // speed over the limit, estop active, both long enough to pass the pipe
  sequence s_over_held;
    (eng_speed > ovs_q)[*6];
  endsequence
  sequence s_stop_held;
    (estop_pin == ctrl_q[`EPM_CTRL_ESTOP_HI])[*6];
  endsequence

  a_ready_high: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low outside reset");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_rdata_hold: assert property (!rd_req |=> $stable(hrdata))
    else $error("hrdata changed without a read");
  a_unmapped_zero: assert property (
    rd_req && haddr[7:0] > `EPM_OFF_EVT_CLR |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ovs_readback:
    assert property (rd_req && haddr[7:0] == `EPM_OFF_OVS_THR
      |=> hrdata == {{(32-DW){1'b0}}, ovs_q})
    else $error("overspeed limit readback wrong");
  a_ctrl_readback:
    assert property (rd_req && haddr[7:0] == `EPM_OFF_CTRL
      |=> hrdata == {29'h0, ctrl_q})
    else $error("control readback wrong");
  a_over_shut:
    assert property (s_over_held |-> shutdown)
    else $error("overspeed without shutdown");
  a_estop_shut:
    assert property (s_stop_held |-> shutdown)
    else $error("estop active without shutdown");
  a_inhibit_shut:
    assert property (restart_inhibit |-> shutdown)
    else $error("inhibit without shutdown");
  a_latch_clear:
    assert property ($fell(restart_inhibit) |-> clr_age_q <= 8'h04)
    else $error("inhibit dropped without a clear");
endmodule // epm_checker

// file: verif/epm_sensor_model.sv
// sensor and engine data-link model driving the measurement pins
`timescale 1ns/1ns
module epm_sensor_model #(
  parameter DW = 16
) (
  input  wire logic          hclk,
  input  wire logic          slow,
  input  wire logic [DW-1:0] spd_set,
  input  wire logic [DW-1:0] oil_set,
  input  wire logic [DW-1:0] cool_set,
  input  wire logic          est_set,
  output logic      [DW-1:0] eng_speed,
  output logic      [DW-1:0] oil_press,
  output logic      [DW-1:0] cool_temp,
  output logic               estop_pin
);
  // engine at rest, oil pressure at zero, coolant and estop at a safe level
  initial begin
    eng_speed = '0;
    oil_press = '0;
    cool_temp = '0;
    estop_pin = 1'b1;
  end

  // speed ramps when slow so crank speed is crossed gradually
  always @(posedge hclk) begin
    if (slow && eng_speed + 16'h0040 < spd_set)
      eng_speed <= eng_speed + 16'h0040;
    else if (slow && eng_speed > spd_set + 16'h0040)
      eng_speed <= eng_speed - 16'h0040;
    else
      eng_speed <= spd_set;
    oil_press <= oil_set;
    cool_temp <= cool_set;
    estop_pin <= est_set;
  end
endmodule // epm_sensor_model

// file: verif/test_epm_top.sv
// self-checking bench for the engine protection monitor
`timescale 1ns/1ns
`include "epm_regs.vh"
module test_epm_top;
  localparam DW = 16;
  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic          shutdown, oil_warn, cool_warn, restart_inhibit;
  logic [DW-1:0] spd_set, oil_set, cool_set;
  logic [DW-1:0] eng_speed, oil_press, cool_temp;
  logic          est_set, slow, estop_pin;
  int            miscompares, num_checks;

  epm_top #(.DW(DW), .TICK_CYC(4), .TICKS_HOUR(10)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .eng_speed(eng_speed), .oil_press(oil_press),
    .cool_temp(cool_temp), .estop_pin(estop_pin), .shutdown(shutdown),
    .oil_warn(oil_warn), .cool_warn(cool_warn),
    .restart_inhibit(restart_inhibit));

  epm_sensor_model #(.DW(DW)) i_sens (
    .hclk(hclk), .slow(slow), .spd_set(spd_set), .oil_set(oil_set),
    .cool_set(cool_set), .est_set(est_set), .eng_speed(eng_speed),
    .oil_press(oil_press), .cool_temp(cool_temp), .estop_pin(estop_pin));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // --------
  // checking and bus tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    if (hreadyout !== 1'b1) begin
      chk(32'h0, 32'h1);
      tally_and_finish;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic stb(input int b, input logic v);
    logic [31:0] r;
    bus(1'b0, `EPM_OFF_STATUS, 32'h0, r);
    chk({31'h0, r[b]}, {31'h0, v});
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? shutdown : s == 1 ? oil_warn : cool_warn;
  endfunction

  // wait a bounded time for an output to reach a level
  task automatic wait_for(input int s, input logic v, input int n);
    int i;
    for (i = 0; i < n && pick(s) !== v; i++) @(posedge hclk);
    chk({31'h0, pick(s)}, {31'h0, v});
    if (pick(s) !== v) tally_and_finish;
  endtask

  // output must stay at a level for n cycles
  task automatic hold(input int s, input logic v, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge hclk);
      if (pick(s) !== v) ok = 1'b0;
    end
    chk({31'h0, ok}, 32'h1);
  endtask

  // --------
  // scenarios
  // --------
  task automatic t_reset_vals;
    logic [15:0] rv [11];
    int i;
    rv = '{16'h0, `EPM_RST_OVS_THR, `EPM_RST_OIL_WARN, `EPM_RST_OIL_SD,
           `EPM_RST_OIL_DLY, `EPM_RST_COOL_WARN, `EPM_RST_COOL_SD,
           `EPM_RST_COOL_DLY, `EPM_RST_MASK_DLY, `EPM_RST_CRANK_SPD, 16'h0};
    for (i = 0; i < 11; i++) rdc(8'(i * 4), {16'h0, rv[i]});
    wr(8'h34, 32'h5);
    rdc(8'h34, 32'h0);
  endtask

  task automatic t_oil;
    wr(`EPM_OFF_MASK_DLY, 32'ha);
    wr(`EPM_OFF_OIL_DLY, 32'h5);
    oil_set <= `EPM_RST_OIL_SD;
    wait_for(1, 1'b1, 8);
    hold(0, 1'b0, 60);
    spd_set <= 16'h0300;
    hold(0, 1'b0, 35);
    wait_for(0, 1'b1, 80);
    oil_set <= 16'h0100;
    wait_for(1, 1'b0, 8);
    hold(0, 1'b1, 20);
    rdc(`EPM_OFF_STATUS, 32'h0b40);
    wr(`EPM_OFF_EVT_CLR, 32'he0);
    wait_for(0, 1'b0, 8);
    repeat (2) begin
      oil_set <= 16'h00a0;
      hold(0, 1'b0, 10);
      oil_set <= 16'h0100;
      hold(0, 1'b0, 8);
    end
  endtask

  task automatic t_cool;
    wr(`EPM_OFF_COOL_SD, 32'h30);
    rdc(`EPM_OFF_COOL_SD, 32'h6e);
    stb(12, 1'b1);
    wr(`EPM_OFF_COOL_SD, 32'h31);
    stb(12, 1'b0);
    wr(`EPM_OFF_COOL_DLY, 32'h3);
    cool_set <= 16'h0031;
    hold(0, 1'b0, 8);
    wait_for(0, 1'b1, 40);
    chk({31'h0, cool_warn}, 32'h0);
    cool_set <= 16'h0064;
    wait_for(2, 1'b1, 8);
    cool_set <= 16'h0020;
    wait_for(2, 1'b0, 8);
    wr(`EPM_OFF_EVT_CLR, 32'he0);
    wait_for(0, 1'b0, 8);
  endtask

  task automatic t_ovs;
    slow <= 1'b0;
    spd_set <= 16'h0700;
    wr(`EPM_OFF_OVS_THR, 32'h6ff);
    wait_for(0, 1'b1, 8);
    wr(`EPM_OFF_CTRL, 32'h2);
    wr(`EPM_OFF_OVS_THR, 32'h900);
    rdc(`EPM_OFF_OVS_THR, 32'h6ff);
    wr(`EPM_OFF_CTRL, 32'h6);
    wr(`EPM_OFF_OVS_THR, 32'h900);
    rdc(`EPM_OFF_OVS_THR, 32'h900);
    wr(`EPM_OFF_EVT_CLR, 32'he0);
    wait_for(0, 1'b0, 8);
    spd_set <= 16'h0900;
    hold(0, 1'b0, 10);
    spd_set <= 16'h0901;
    wait_for(0, 1'b1, 8);
    spd_set <= 16'h0700;
    hold(0, 1'b1, 6);
    wr(`EPM_OFF_EVT_CLR, 32'he0);
    wait_for(0, 1'b0, 8);
  endtask
  task automatic t_estop;
    est_set <= 1'b0;
    wait_for(0, 1'b1, 8);
    stb(10, 1'b1);
    est_set <= 1'b1;
    wait_for(0, 1'b0, 8);
    wr(`EPM_OFF_CTRL, 32'h7);
    wait_for(0, 1'b1, 8);
    wr(`EPM_OFF_CTRL, 32'h6);
    wait_for(0, 1'b0, 8);
  endtask

  task automatic t_hours;
    logic [31:0] r;
    stb(8, 1'b1);
    spd_set <= 16'h0000;
    repeat (6) @(posedge hclk);
    stb(8, 1'b0);
    bus(1'b0, `EPM_OFF_HOURS, 32'h0, r);
    wr(`EPM_OFF_CTRL, 32'h0);
    wr(`EPM_OFF_HOURS, 32'h100);
    rdc(`EPM_OFF_HOURS, r);
    wr(`EPM_OFF_CTRL, 32'h6);
    wr(`EPM_OFF_HOURS, 32'h100);
    wr(`EPM_OFF_HOURS, 32'hff);
    stb(12, 1'b1);
    repeat (60) @(posedge hclk);
    rdc(`EPM_OFF_HOURS, 32'h100);
    spd_set <= 16'h0300;
    repeat (90) @(posedge hclk);
    bus(1'b0, `EPM_OFF_HOURS, 32'h0, r);
    chk({31'h0, (r == 32'h102 || r == 32'h103)}, 32'h1);
  endtask

  // reset, then the scenarios in turn
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    spd_set = 16'h0000;
    oil_set = 16'h0100;
    cool_set = 16'h0020;
    est_set = 1'b1;
    slow = 1'b1;
    miscompares = 0;
    num_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset_vals;
    t_oil;
    t_cool;
    t_ovs;
    t_estop;
    t_hours;
    tally_and_finish;
  end
endmodule // test_epm_top

bind epm_top epm_checker #(.DW(DW)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .eng_speed(eng_speed), .estop_pin(estop_pin), .shutdown(shutdown),
  .restart_inhibit(restart_inhibit));
